/* File: include/tcp_pkg.sv */
// Package for the Type-C source attach and power-path block
`default_nettype none
package tcp_pkg;
	// Termination seen on one CC line, as classified by the front end
	typedef enum logic [2:0] {
		TERM_OPEN = 3'h0,
		TERM_RA = 3'h1,
		TERM_RD = 3'h2,
		TERM_RP = 3'h3,
		TERM_LOW = 3'h4
	} tcp_term_t;

	typedef struct packed {
		tcp_term_t cc1;
		tcp_term_t cc2;
	} tcp_cc_pair_t;

	// Supply and bus monitor levels
	typedef struct packed {
		logic vdd_supplied;
		logic vdd_above_lockout;
		logic bus_in_range;
	} tcp_mon_t;

	typedef enum {
		ST_UNATTACHED,
		ST_ATTACHED,
		ST_DEBUG_UNORIENTED,
		ST_DEBUG_ORIENTED,
		ST_AUDIO
	} tcp_state_t;

	// Register offsets
	localparam logic [7:0] OFS_CONN_STATUS = 8'h0e;
	localparam logic [7:0] OFS_OP_STATE = 8'h11;
	localparam logic [7:0] OFS_CURRENT_VCONN = 8'h18;
	localparam logic [7:0] OFS_VCONN_ILIM = 8'h1e;
	localparam logic [7:0] OFS_PORT_ROLE = 8'h1f;
	localparam logic [7:0] OFS_VCONN_MON = 8'h20;
	localparam logic [7:0] OFS_BUS_TARGET = 8'h21;
	localparam logic [7:0] OFS_WINDOW_SHIFT = 8'h22;
	localparam logic [7:0] OFS_ACC_DETECT = 8'h24;
	localparam logic [7:0] OFS_DISCH_TIME = 8'h25;
	localparam logic [7:0] OFS_DISCH_EN = 8'h26;
	localparam logic [7:0] OFS_MON_DISABLE = 8'h2e;

	// Connection codes
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_SINK = 8'h2d;
	localparam logic [7:0] CODE_SINK_CABLE = 8'h2f;
	localparam logic [7:0] CODE_DEBUG = 8'h6d;
	localparam logic [7:0] CODE_AUDIO = 8'h81;

	// Attach state report codes
	localparam logic [7:0] OPST_UNATTACHED = 8'h00;
	localparam logic [7:0] OPST_ATTACHED = 8'h01;
	localparam logic [7:0] OPST_DEBUG_UNORIENTED = 8'h02;
	localparam logic [7:0] OPST_DEBUG_ORIENTED = 8'h03;
	localparam logic [7:0] OPST_AUDIO = 8'h04;

	// Field positions
	localparam int BIT_STARTUP_MODE = 0;
	localparam int BIT_VCONN_SUPPLY = 2;
	localparam int BIT_VCONN_DISCH = 3;
	localparam int BIT_ACC_DETECT = 0;
	localparam int BIT_DISCH_EN = 0;
	localparam int BIT_SUPPLY_OVERVOLTAGE_LOCKOUT_OFF = 0;
	localparam int BIT_RANGE_OFF = 1;

	// Reset values
	localparam logic RST_STARTUP_MODE = 1'b0;
	localparam logic [1:0] RST_CURRENT_LEVEL = 2'h0;
	localparam logic RST_VCONN_SUPPLY = 1'b1;
	localparam logic RST_VCONN_DISCH = 1'b0;
	localparam logic [3:0] RST_VCONN_ILIM = 4'h0;
	localparam logic [2:0] RST_PORT_ROLE = 3'h1;
	localparam logic [1:0] RST_VCONN_MON = 2'h0;
	localparam logic [7:0] RST_BUS_TARGET = 8'h32;
	localparam logic [3:0] RST_SHIFT = 4'ha;
	localparam logic RST_ACC_DETECT = 1'b1;
	localparam logic [3:0] RST_DISCH_TIME = 4'ha;
	localparam logic RST_DISCH_EN = 1'b1;
	localparam logic RST_SUPPLY_OVERVOLTAGE_LOCKOUT_OFF = 1'b0;
	localparam logic RST_RANGE_OFF = 1'b0;
endpackage : tcp_pkg
`default_nettype wire

/* File: design/tcp_attach_power.sv */
// Source-role attach decoding, power-path outputs and start-up registers
`default_nettype none

module tcp_attach_power
	import tcp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// CC termination classification from the analog front end
	input wire tcp_cc_pair_t cc_term_pin,
	// Supply and bus monitors
	input wire tcp_mon_t mon_pin,
	// Register access port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Source power switch enable, open drain
	output logic source_switch_enable_n_out,
	output logic source_switch_enable_n_oe,
	// Orientation output, open drain
	output logic side_out,
	output logic side_oe,
	// VCONN supply switches
	output logic vconn_cc1_on,
	output logic vconn_cc2_on,
	// Configuration seen by the rest of the port
	output logic startup_standby,
	output logic [7:0] bus_voltage_target_code,
	output logic [3:0] upper_window_shift,
	output logic [3:0] lower_window_shift,
	output logic powered_accessory_detect_on,
	output logic discharge_path_on
);

	tcp_cc_pair_t cc_meta_reg;
	tcp_cc_pair_t cc_sync_reg;
	tcp_cc_pair_t cc_prev_reg;
	tcp_mon_t mon_meta_reg;
	tcp_mon_t mon_sync_reg;
	tcp_state_t state_reg;
	tcp_state_t state_next;
	logic [7:0] code_reg;
	logic [7:0] code_next;
	logic cc2_sink_reg;
	logic cc2_sink_next;
	logic vconn_on_ra_reg;
	logic vconn_on_ra_next;
	logic en_oe_reg;
	logic side_oe_reg;
	logic vconn1_reg;
	logic vconn2_reg;
	logic [7:0] rdata_reg;
	logic startup_mode_reg;
	logic [1:0] current_level_reg;
	logic vconn_supply_reg;
	logic vconn_disch_reg;
	logic [3:0] vconn_ilim_reg;
	logic [2:0] port_role_reg;
	logic [1:0] vconn_mon_reg;
	logic [7:0] bus_target_reg;
	logic [3:0] shift_high_reg;
	logic [3:0] shift_low_reg;
	logic acc_detect_reg;
	logic [3:0] disch_zero_reg;
	logic [3:0] disch_trans_reg;
	logic disch_en_reg;
	logic supply_overvoltage_lockout_off_reg;
	logic range_off_reg;
	logic [7:0] op_code;
	logic [7:0] read_mux;
	logic powered_state;
	logic supply_ok;
	logic bus_ok;
	logic stable;
	logic is_rd1;
	logic is_rd2;

	// Two-stage synchronisers; only the second stage is read
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cc_meta_reg <= '{TERM_OPEN, TERM_OPEN};
			cc_sync_reg <= '{TERM_OPEN, TERM_OPEN};
			mon_meta_reg <= '0;
			mon_sync_reg <= '0;
		end else begin
			cc_meta_reg <= cc_term_pin;
			cc_sync_reg <= cc_meta_reg;
			mon_meta_reg <= mon_pin;
			mon_sync_reg <= mon_meta_reg;
		end
	end

	// A multi-bit code can tear across the synchroniser, so the pair is
	// only trusted once two samples agree
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cc_prev_reg <= '{TERM_OPEN, TERM_OPEN};
		end else begin
			cc_prev_reg <= cc_sync_reg;
		end
	end

	assign stable = (cc_prev_reg == cc_sync_reg);
	assign is_rd1 = (cc_sync_reg.cc1 == TERM_RD);
	assign is_rd2 = (cc_sync_reg.cc2 == TERM_RD);

	// Termination pair decode
	always_comb begin
		state_next = ST_UNATTACHED;
		code_next = CODE_NONE;
		cc2_sink_next = is_rd2 && !is_rd1;
		vconn_on_ra_next = 1'b0;
		unique case ({cc_sync_reg.cc1, cc_sync_reg.cc2})
			{TERM_RD, TERM_OPEN}, {TERM_OPEN, TERM_RD}: begin
				state_next = ST_ATTACHED;
				code_next = CODE_SINK;
			end
			{TERM_RD, TERM_RA}, {TERM_RA, TERM_RD}: begin
				state_next = ST_ATTACHED;
				code_next = CODE_SINK_CABLE;
				vconn_on_ra_next = 1'b1;
			end
			{TERM_RD, TERM_RD}: begin
				state_next = ST_DEBUG_UNORIENTED;
				code_next = CODE_DEBUG;
			end
			{TERM_RD, TERM_LOW}, {TERM_LOW, TERM_RD}: begin
				state_next = ST_DEBUG_ORIENTED;
				code_next = CODE_DEBUG;
			end
			{TERM_RA, TERM_RA}: begin
				state_next = ST_AUDIO;
				code_next = CODE_AUDIO;
			end
			default: begin
				state_next = ST_UNATTACHED;
				code_next = CODE_NONE;
			end
		endcase
	end

	// Attach state; the status follows each decoded pair that holds for two samples, so a partner
	// plugging in may pass through other codes on the way
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= ST_UNATTACHED;
			code_reg <= CODE_NONE;
			cc2_sink_reg <= 1'b0;
			vconn_on_ra_reg <= 1'b0;
		end else if (stable) begin
			state_reg <= state_next;
			code_reg <= code_next;
			cc2_sink_reg <= cc2_sink_next;
			vconn_on_ra_reg <= vconn_on_ra_next;
		end
	end

	// Power switch enable conditions
	assign powered_state = (state_reg == ST_ATTACHED) ||
		(state_reg == ST_DEBUG_UNORIENTED) ||
		(state_reg == ST_DEBUG_ORIENTED);
	assign supply_ok = !mon_sync_reg.vdd_supplied || supply_overvoltage_lockout_off_reg ||
		!mon_sync_reg.vdd_above_lockout;
	assign bus_ok = range_off_reg || mon_sync_reg.bus_in_range;

	// Re-evaluated every cycle, so any input change shows at the pin
	// within five edges
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_oe_reg <= 1'b0;
		end else begin
			en_oe_reg <= powered_state && supply_ok && bus_ok;
		end
	end

	// Orientation and VCONN
	always_ff @(posedge clk) begin
		if (!rstn) begin
			side_oe_reg <= 1'b0;
			vconn1_reg <= 1'b0;
			vconn2_reg <= 1'b0;
		end else begin
			side_oe_reg <= cc2_sink_reg && ((state_reg == ST_ATTACHED) ||
				(state_reg == ST_DEBUG_ORIENTED));
			vconn1_reg <= (state_reg == ST_ATTACHED) && vconn_on_ra_reg &&
				cc2_sink_reg && vconn_supply_reg;
			vconn2_reg <= (state_reg == ST_ATTACHED) && vconn_on_ra_reg &&
				!cc2_sink_reg && vconn_supply_reg;
		end
	end

	assign source_switch_enable_n_out = 1'b0;
	assign source_switch_enable_n_oe = en_oe_reg;
	assign side_out = 1'b0;
	assign side_oe = side_oe_reg;
	assign vconn_cc1_on = vconn1_reg;
	assign vconn_cc2_on = vconn2_reg;

	// Configuration registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			startup_mode_reg <= RST_STARTUP_MODE;
			current_level_reg <= RST_CURRENT_LEVEL;
			vconn_supply_reg <= RST_VCONN_SUPPLY;
			vconn_disch_reg <= RST_VCONN_DISCH;
			vconn_ilim_reg <= RST_VCONN_ILIM;
			port_role_reg <= RST_PORT_ROLE;
			vconn_mon_reg <= RST_VCONN_MON;
			shift_high_reg <= RST_SHIFT;
			shift_low_reg <= RST_SHIFT;
			acc_detect_reg <= RST_ACC_DETECT;
			disch_zero_reg <= RST_DISCH_TIME;
			disch_trans_reg <= RST_DISCH_TIME;
			disch_en_reg <= RST_DISCH_EN;
			supply_overvoltage_lockout_off_reg <= RST_SUPPLY_OVERVOLTAGE_LOCKOUT_OFF;
			range_off_reg <= RST_RANGE_OFF;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				OFS_CONN_STATUS: begin
					startup_mode_reg <= reg_wdata[BIT_STARTUP_MODE];
				end
				OFS_CURRENT_VCONN: begin
					current_level_reg <= reg_wdata[1:0];
					vconn_supply_reg <= reg_wdata[BIT_VCONN_SUPPLY];
					vconn_disch_reg <= reg_wdata[BIT_VCONN_DISCH];
				end
				OFS_VCONN_ILIM: begin
					vconn_ilim_reg <= reg_wdata[3:0];
				end
				OFS_PORT_ROLE: begin
					port_role_reg <= reg_wdata[2:0];
				end
				OFS_VCONN_MON: begin
					vconn_mon_reg <= reg_wdata[1:0];
				end
				OFS_WINDOW_SHIFT: begin
					shift_high_reg <= reg_wdata[7:4];
					shift_low_reg <= reg_wdata[3:0];
				end
				OFS_ACC_DETECT: begin
					acc_detect_reg <= reg_wdata[BIT_ACC_DETECT];
				end
				OFS_DISCH_TIME: begin
					disch_zero_reg <= reg_wdata[7:4];
					disch_trans_reg <= reg_wdata[3:0];
				end
				OFS_DISCH_EN: begin
					disch_en_reg <= reg_wdata[BIT_DISCH_EN];
				end
				OFS_MON_DISABLE: begin
					supply_overvoltage_lockout_off_reg <= reg_wdata[BIT_SUPPLY_OVERVOLTAGE_LOCKOUT_OFF];
					range_off_reg <= reg_wdata[BIT_RANGE_OFF];
				end
				default: begin
				end
			endcase
		end
	end

	// Bus target: software writes it, and the state machine restores the
	// 5 V code on detach, except that a target write in the same cycle wins and is kept
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus_target_reg <= RST_BUS_TARGET;
		end else if (reg_wr_en && reg_addr == OFS_BUS_TARGET) begin
			bus_target_reg <= reg_wdata;
		end else if (stable && state_next == ST_UNATTACHED &&
			state_reg != ST_UNATTACHED) begin
			bus_target_reg <= RST_BUS_TARGET;
		end
	end

	// Attach state report code
	always_comb begin
		op_code = OPST_UNATTACHED;
		unique case (state_reg)
			ST_UNATTACHED: op_code = OPST_UNATTACHED;
			ST_ATTACHED: op_code = OPST_ATTACHED;
			ST_DEBUG_UNORIENTED: op_code = OPST_DEBUG_UNORIENTED;
			ST_DEBUG_ORIENTED: op_code = OPST_DEBUG_ORIENTED;
			ST_AUDIO: op_code = OPST_AUDIO;
		endcase
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		read_mux = 8'h00;
		unique case (reg_addr)
			OFS_CONN_STATUS: read_mux = code_reg;
			OFS_OP_STATE: read_mux = op_code;
			OFS_CURRENT_VCONN: read_mux = {4'h0, vconn_disch_reg,
				vconn_supply_reg, current_level_reg};
			OFS_VCONN_ILIM: read_mux = {4'h0, vconn_ilim_reg};
			OFS_PORT_ROLE: read_mux = {5'h00, port_role_reg};
			OFS_VCONN_MON: read_mux = {6'h00, vconn_mon_reg};
			OFS_BUS_TARGET: read_mux = bus_target_reg;
			OFS_WINDOW_SHIFT: read_mux = {shift_high_reg, shift_low_reg};
			OFS_ACC_DETECT: read_mux = {7'h00, acc_detect_reg};
			OFS_DISCH_TIME: read_mux = {disch_zero_reg, disch_trans_reg};
			OFS_DISCH_EN: read_mux = {7'h00, disch_en_reg};
			OFS_MON_DISABLE: read_mux = {6'h00, range_off_reg, supply_overvoltage_lockout_off_reg};
			default: read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= read_mux;
		end
	end

	assign reg_rdata = rdata_reg;
	assign startup_standby = startup_mode_reg;
	assign bus_voltage_target_code = bus_target_reg;
	assign upper_window_shift = shift_high_reg;
	assign lower_window_shift = shift_low_reg;
	assign powered_accessory_detect_on = acc_detect_reg;
	assign discharge_path_on = disch_en_reg;

endmodule : tcp_attach_power
`default_nettype wire

/* File: verif/tcp_attach_power_sva.sv */
// Assertion checker for the attach and power-path block
`default_nettype none
module tcp_attach_power_sva import tcp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Port inputs
	input wire tcp_cc_pair_t cc_term_pin,
	input wire tcp_mon_t mon_pin,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	// Port outputs
	input wire logic [7:0] reg_rdata,
	input wire logic source_switch_enable_n_out,
	input wire logic source_switch_enable_n_oe,
	input wire logic side_out,
	input wire logic side_oe,
	input wire logic vconn_cc1_on,
	input wire logic vconn_cc2_on,
	input wire logic startup_standby,
	input wire logic [7:0] bus_voltage_target_code,
	input wire logic [3:0] upper_window_shift,
	input wire logic [3:0] lower_window_shift,
	input wire logic powered_accessory_detect_on,
	input wire logic discharge_path_on
);
	wire logic [5:0] cc = cc_term_pin;
	wire logic en = source_switch_enable_n_oe;
	wire logic vc = vconn_cc1_on | vconn_cc2_on;
	// Eight settled cycles cover sync, debounce and output stages
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_off; (cc == 6'h00)[*8] |=> !en && !side_oe && !vc; endproperty
	a_off: assert property (p_off)
		else $error("outputs active with both lines open");
	property p_att;
		(cc == 6'h10 && mon_pin == 3'h1)[*8] |=> en && !side_oe && !vc;
	endproperty
	a_att: assert property (p_att)
		else $error("sink on first line not served");
	property p_cab;
		(cc == 6'h11)[*8] |=> vconn_cc2_on && !vconn_cc1_on;
	endproperty
	a_cab: assert property (p_cab)
		else $error("cable supply on wrong line");
	property p_side; (cc_term_pin.cc2 != TERM_RD)[*8] |=> !side_oe; endproperty
	a_side: assert property (p_side)
		else $error("orientation driven without sink on second line");
	property p_dbg; (cc == 6'h12)[*8] |=> !side_oe && !vc; endproperty
	a_dbg: assert property (p_dbg)
		else $error("unoriented debug drives side or supply");
	property p_ori;
		(cc == 6'h22 && mon_pin == 3'h1)[*8] |=> en && side_oe && !vc;
	endproperty
	a_ori: assert property (p_ori)
		else $error("oriented debug on second line not served");
	property p_rp; (cc == 6'h1b)[*8] |=> !en && !vc; endproperty
	a_rp: assert property (p_rp)
		else $error("source pair treated as attach");
	property p_aud; (cc == 6'h09)[*8] |=> !en && !vc; endproperty
	a_aud: assert property (p_aud)
		else $error("audio accessory powered");
	property p_rng; (!mon_pin.bus_in_range)[*4] |=> !en; endproperty
	a_rng: assert property (p_rng)
		else $error("switch held with bus out of range");
	property p_supply_overvoltage_lockout; (mon_pin == 3'h7)[*4] |=> !en; endproperty
	a_supply_overvoltage_lockout: assert property (p_supply_overvoltage_lockout)
		else $error("switch held with supply over lockout");
	property p_low; !source_switch_enable_n_out && !side_out; endproperty
	a_low: assert property (p_low)
		else $error("open drain level not low");
endmodule : tcp_attach_power_sva

bind tcp_attach_power tcp_attach_power_sva u_sva (
	.clk(clk), .rstn(rstn), .cc_term_pin(cc_term_pin), .mon_pin(mon_pin),
	.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.source_switch_enable_n_out(source_switch_enable_n_out),
	.source_switch_enable_n_oe(source_switch_enable_n_oe),
	.side_out(side_out), .side_oe(side_oe),
	.vconn_cc1_on(vconn_cc1_on), .vconn_cc2_on(vconn_cc2_on),
	.startup_standby(startup_standby),
	.bus_voltage_target_code(bus_voltage_target_code),
	.upper_window_shift(upper_window_shift),
	.lower_window_shift(lower_window_shift),
	.powered_accessory_detect_on(powered_accessory_detect_on),
	.discharge_path_on(discharge_path_on)
);
`default_nettype wire

/* File: verif/tcp_partner.sv */
// Far-side model: CC terminations and supply and bus monitor levels
`default_nettype none
module tcp_partner import tcp_pkg::*; (
	// Clock
	input wire logic clk,
	// Commanded attachment
	input wire tcp_cc_pair_t want_cc,
	input wire tcp_mon_t want_mon,
	// Levels seen by the port
	output var tcp_cc_pair_t cc_term_pin,
	output var tcp_mon_t mon_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	tcp_cc_pair_t last_cc = '0;
	initial begin
		cc_term_pin = '0;
		mon_pin = '0;
	end
	// Plugs bounce: the first cycle of a change reads as a foreign pair
	always @(posedge clk) begin
		last_cc <= want_cc;
		mon_pin <= want_mon;
		if (want_cc != last_cc) begin
			cc_term_pin <= {TERM_RP, TERM_RP};
		end else begin
			cc_term_pin <= want_cc;
		end
	end
endmodule : tcp_partner
`default_nettype wire

/* File: verif/tcp_attach_power_test.sv */
// Self-checking bench for the attach and power-path block
`default_nettype none
module tcp_attach_power_test import tcp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	tcp_cc_pair_t want_cc = '0;
	tcp_cc_pair_t cc;
	tcp_mon_t want_mon = 3'h1;
	tcp_mon_t mon;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr_en = 1'b0;
	logic [7:0] rdata, target;
	logic sw_out, sw_oe, side_out, side_oe, v1, v2, stby, acc, disch;
	logic [3:0] up, lo, m;
	logic [31:0] e;
	int num_errors = 0;
	int tests_run = 0;
	logic [7:0] ra [13] = '{8'h1f, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h2e,
		8'h0e, 8'h11, 8'h18, 8'h1e, 8'h20, 8'h30};
	logic [7:0] rv [13] = '{8'h01, 8'h32, 8'haa, 8'h01, 8'haa, 8'h01, 8'h00,
		8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
	// cc1, cc2, code, state report, {switch, side, vconn1, vconn2}
	logic [31:0] dt [13] = '{32'h00000000, 32'h202d0108, 32'h022d010c,
		32'h01000000, 32'h10000000, 32'h212f0109, 32'h122f010e,
		32'h33000000, 32'h226d0208, 32'h246d0308, 32'h426d030c,
		32'h11810400, 32'h23000000};
	// Monitor levels and the switch state they allow
	logic [3:0] mt [5] = '{4'h3, 4'h0, 4'he, 4'h7, 4'hb};

	always #5 clk = ~clk;

	tcp_partner partner (.clk(clk), .want_cc(want_cc), .want_mon(want_mon),
		.cc_term_pin(cc), .mon_pin(mon));
	tcp_attach_power dut (.clk(clk), .rstn(rstn), .cc_term_pin(cc),
		.mon_pin(mon), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rdata(rdata),
		.source_switch_enable_n_out(sw_out),
		.source_switch_enable_n_oe(sw_oe), .side_out(side_out),
		.side_oe(side_oe), .vconn_cc1_on(v1), .vconn_cc2_on(v2),
		.startup_standby(stby), .bus_voltage_target_code(target),
		.upper_window_shift(up), .lower_window_shift(lo),
		.powered_accessory_detect_on(acc), .discharge_path_on(disch));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		tick(1);
		reg_wr_en = 1'b0;
		tick(1);
	endtask : wr

	// Read data lags the address by one edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		tick(1);
		chk(rdata, exp);
	endtask : rd

	task automatic results;
		if (num_errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	initial begin
		#20000;
		num_errors++;
		results();
	end

	initial begin
		tick(6);
		rstn = 1'b1;
		for (int i = 0; i < 13; i++) begin
			rd(ra[i], rv[i]);
		end
		chk({5'h0, stby, acc, disch}, 8'h03);
		chk({up, lo}, 8'haa);
		chk(target, 8'h32);
		wr(8'h21, 8'h64);
		chk(target, 8'h64);
		rd(8'h21, 8'h64);
		wr(8'h11, 8'h03);
		rd(8'h11, 8'h00);
		wr(8'h0e, 8'h01);
		chk({7'h0, stby}, 8'h01);
		wr(8'h0e, 8'h00);
		wr(8'h22, 8'h5c);
		chk({up, lo}, 8'h5c);
		wr(8'h26, 8'h00);
		chk({7'h0, disch}, 8'h00);
		for (int i = 0; i < 13; i++) begin
			e = dt[i];
			want_cc = {e[30:28], e[26:24]};
			tick(12);
			rd(OFS_CONN_STATUS, e[23:16]);
			rd(OFS_OP_STATE, e[15:8]);
			chk({4'h0, sw_oe, side_oe, v1, v2}, {4'h0, e[3:0]});
		end
		chk(target, 8'h32);
		want_cc = 6'h10;
		tick(12);
		for (int i = 0; i < 5; i++) begin
			m = mt[i];
			want_mon = m[3:1];
			tick(6);
			chk({7'h0, sw_oe}, {7'h0, m[0]});
		end
		chk({6'h0, sw_out, side_out}, 8'h00);
		rstn = 1'b0;
		tick(2);
		rstn = 1'b1;
		chk({7'h0, sw_oe}, 8'h00);
		tick(12);
		chk({7'h0, sw_oe}, 8'h01);
		results();
	end
endmodule : tcp_attach_power_test
`default_nettype wire
